// [src/sbrg_top.sv]
// Baud rate generator with APB register access and serial clock pin
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module sbrg_top #(
	parameter int PRE_DIV = sbrg_pkg::PRE_DIV
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        sckIn,
	output logic             sckOut,
	output var  logic        sckOe,
	output var  logic        sampleTick,
	output var  logic        bitTick
);

	// ==========================================================
	// APB slave: one wait state, answer registered
	sbrg_pkg::sbrg_cfg_t cfg_r;
	sbrg_pkg::sbrg_cfg_t cfg_nxt;
	logic        access;
	logic        wrEn;
	logic        hitCtrl;
	logic        hitMode;
	logic        hitBaud;
	logic        hitStat;
	logic        mapped;
	logic [31:0] rdMux;
	logic [31:0] modeRd;
	logic [31:0] baudRd;
	logic [31:0] statRd;

	assign access  = psel & penable;
	assign wrEn    = access & pready & pwrite;
	assign hitCtrl = paddr == sbrg_pkg::CTRL_OFS;
	assign hitMode = paddr == sbrg_pkg::MODE_OFS;
	assign hitBaud = paddr == sbrg_pkg::BAUD_OFS;
	assign hitStat = paddr == sbrg_pkg::STAT_OFS;
	assign mapped  = hitCtrl | hitMode | hitBaud | hitStat;

	// Writes land whether or not the unit runs
	always_comb begin
		cfg_nxt = cfg_r;
		if (wrEn && hitCtrl) begin
			cfg_nxt.unitOn = pwdata[sbrg_pkg::CTRL_RUN_BIT];
		end
		if (wrEn && hitMode) begin
			cfg_nxt.special  = pwdata[sbrg_pkg::MODE_SPEC_LSB +: 4];
			cfg_nxt.clkSel   = pwdata[sbrg_pkg::MODE_SEL_LSB +: 2];
			cfg_nxt.syncMode = pwdata[sbrg_pkg::MODE_SYNC_BIT];
			cfg_nxt.over     = pwdata[sbrg_pkg::MODE_OVER_BIT];
		end
		if (wrEn && hitBaud) begin
			cfg_nxt.divisor = pwdata[15:0];
			cfg_nxt.frac    = pwdata[sbrg_pkg::BAUD_FRAC_LSB +: 3];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r   <= sbrg_pkg::CFG_RESET;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= sbrg_pkg::REG_RESET;
		end else begin
			cfg_r   <= cfg_nxt;
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			if (access && !pready && !pwrite) begin
				prdata <= rdMux;
			end
		end
	end

	// ==========================================================
	// Source selection
	logic       run;
	logic       sckMeta_r;
	logic       sckSync_r;
	logic       sckPrev_r;
	logic       extRise;
	logic [7:0] preCnt_r;
	logic       preTick;
	logic       srcTick;

	assign run     = cfg_r.unitOn;
	assign extRise = sckSync_r & ~sckPrev_r;
	assign preTick = preCnt_r == 8'(PRE_DIV - 1);
	assign srcTick = run & ((cfg_r.clkSel == sbrg_pkg::SRC_MCK) |
		((cfg_r.clkSel == sbrg_pkg::SRC_MCKDIV) & preTick) |
		((cfg_r.clkSel == sbrg_pkg::SRC_EXT) & extRise));

	// The pin is free running, so it is watched even while the unit is off
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sckMeta_r <= 1'b0;
			sckSync_r <= 1'b0;
			sckPrev_r <= 1'b0;
		end else begin
			sckMeta_r <= sckIn;
			sckSync_r <= sckMeta_r;
			sckPrev_r <= sckSync_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			preCnt_r <= 8'h00;
		end else if (run) begin
			preCnt_r <= preTick ? 8'h00 : preCnt_r + 8'h01;
		end
	end

	// ==========================================================
	// Integer and fractional divider
	logic [15:0] cnt_r;
	logic [2:0]  fracAcc_r;
	logic        stretch_r;
	logic [15:0] lastCnt;
	logic        divZero;
	logic        bypass;
	logic        extDirect;
	logic        fracOn;
	logic [3:0]  accSum;
	logic        periodEnd;
	logic        divTick;

	assign divZero   = cfg_r.divisor == 16'h0000;
	assign bypass    = cfg_r.divisor == 16'h0001;
	assign extDirect = cfg_r.syncMode & (cfg_r.clkSel == sbrg_pkg::SRC_EXT);
	assign fracOn    = (cfg_r.frac != 3'h0) & ~cfg_r.syncMode &
		(cfg_r.special == sbrg_pkg::MODE_NORMAL);
	assign accSum    = {1'b0, fracAcc_r} + {1'b0, cfg_r.frac};
	// A carry out of the eighth accumulator lengthens the next period by one
	assign lastCnt   = cfg_r.divisor - 16'h0001 + {15'h0000, stretch_r};
	assign periodEnd = srcTick & (cnt_r >= lastCnt);
	assign divTick   = ~divZero & (bypass ? srcTick : periodEnd);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r     <= 16'h0000;
			fracAcc_r <= 3'h0;
			stretch_r <= 1'b0;
		end else if (periodEnd || (run && divZero)) begin
			cnt_r     <= 16'h0000;
			fracAcc_r <= fracOn ? accSum[2:0] : 3'h0;
			stretch_r <= fracOn & accSum[3];
		end else if (srcTick) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// ==========================================================
	// Sampling clock, bit clock
	logic [3:0] ovsCnt_r;
	logic [3:0] ovsTop;
	logic       ovsEnd;
	logic       sampleNxt;
	logic       bitNxt;

	assign ovsTop    = cfg_r.over ? sbrg_pkg::OVS_TOP8 : sbrg_pkg::OVS_TOP16;
	assign ovsEnd    = ovsCnt_r >= ovsTop;
	assign sampleNxt = ~cfg_r.syncMode & divTick;
	assign bitNxt    = cfg_r.syncMode ?
		(extDirect ? srcTick : divTick) :
		(sampleNxt & ovsEnd);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovsCnt_r   <= 4'h0;
			sampleTick <= 1'b0;
			bitTick    <= 1'b0;
		end else begin
			sampleTick <= sampleNxt;
			bitTick    <= bitNxt;
			if (sampleNxt) begin
				ovsCnt_r <= ovsEnd ? 4'h0 : ovsCnt_r + 4'h1;
			end
		end
	end

	// ==========================================================
	// Serial clock pin drive
	// High for the first half of the count; with the undivided master
	// clock an odd divisor gets an extra half cycle from a falling-edge
	// copy, the only way to a 50:50 ratio on odd counts.
	logic sckPos_r;
	logic sckNeg_r;
	logic oddMck_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sckPos_r <= 1'b0;
			oddMck_r <= 1'b0;
			sckOe    <= 1'b0;
		end else begin
			if (run) begin
				sckPos_r <= ~divZero & (cnt_r < {1'b0, cfg_r.divisor[15:1]});
			end
			oddMck_r <= cfg_r.divisor[0] &
				(cfg_r.clkSel == sbrg_pkg::SRC_MCK);
			sckOe    <= cfg_r.syncMode & ~divZero &
				(cfg_r.clkSel != sbrg_pkg::SRC_EXT);
		end
	end

	always_ff @(negedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sckNeg_r <= 1'b0;
		end else begin
			sckNeg_r <= sckPos_r;
		end
	end

	assign sckOut = sckPos_r | (sckNeg_r & oddMck_r);

	// ==========================================================
	// Read-back
	assign modeRd = (32'(cfg_r.special) << sbrg_pkg::MODE_SPEC_LSB) |
		(32'(cfg_r.clkSel) << sbrg_pkg::MODE_SEL_LSB) |
		(32'(cfg_r.syncMode) << sbrg_pkg::MODE_SYNC_BIT) |
		(32'(cfg_r.over) << sbrg_pkg::MODE_OVER_BIT);
	assign baudRd = 32'(cfg_r.divisor) |
		(32'(cfg_r.frac) << sbrg_pkg::BAUD_FRAC_LSB);
	assign statRd = 32'(cnt_r) |
		(32'(sckPos_r) << sbrg_pkg::STAT_SCK_BIT) |
		(32'(stretch_r) << sbrg_pkg::STAT_STRETCH_BIT);
	assign rdMux  = hitCtrl ? 32'(cfg_r.unitOn) :
		hitMode ? modeRd :
		hitBaud ? baudRd :
		hitStat ? statRd : 32'h0000_0000;

	// ==========================================================
	// Assertions
	logic mck3;
	assign mck3 = run & ~cfg_r.syncMode & (cfg_r.clkSel == sbrg_pkg::SRC_MCK) &
		(cfg_r.divisor == 16'h0003) & (cfg_r.frac == 3'h0);

	a_zero_no_clock: assert property (@(posedge sys_clk) disable iff (!rst_b)
		divZero && !extDirect |=> !sampleTick && !bitTick)
		else $error("clock produced with zero divisor");

	a_bypass_pass: assert property (@(posedge sys_clk) disable iff (!rst_b)
		run && bypass && !cfg_r.syncMode && cfg_r.clkSel == sbrg_pkg::SRC_MCK
		|=> sampleTick)
		else $error("bypass did not pass master clock");

	a_int_period: assert property (@(posedge sys_clk)
		disable iff (!rst_b || wrEn)
		$past(sampleTick, 3) && $past(mck3) && $past(mck3, 2) &&
		$past(mck3, 3) && $past(mck3, 4)
		|-> sampleTick && !$past(sampleTick) && !$past(sampleTick, 2))
		else $error("divide by three period wrong");

	a_bit_on_sample: assert property (@(posedge sys_clk) disable iff (!rst_b)
		bitTick && !$past(cfg_r.syncMode) |-> sampleTick)
		else $error("async bit clock without sampling clock");

	a_stop_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!run |=> $stable(cnt_r) && $stable(fracAcc_r) && !bitTick)
		else $error("divider moved while unit stopped");

	a_frac_normal: assert property (@(posedge sys_clk) disable iff (!rst_b)
		periodEnd && !fracOn |=> !stretch_r && fracAcc_r == 3'h0)
		else $error("fraction active outside normal async mode");

	a_ext_direct: assert property (@(posedge sys_clk) disable iff (!rst_b)
		extDirect && srcTick |=> bitTick)
		else $error("external edge did not give bit clock");

	a_sync_no_ovs: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cfg_r.syncMode |=> !sampleTick)
		else $error("sampling clock in synchronous mode");

	a_cfg_when_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wrEn && hitBaud && !run |=> cfg_r.divisor == $past(pwdata[15:0]))
		else $error("divisor write lost while stopped");

	a_apb_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
		access && !pready |=> pready ##1 !pready)
		else $error("APB answer timing wrong");

	c_frac_stretch: cover property (@(posedge sys_clk) disable iff (!rst_b)
		periodEnd && stretch_r);
	c_over8_bit: cover property (@(posedge sys_clk) disable iff (!rst_b)
		bitTick && cfg_r.over && !cfg_r.syncMode);
	c_ext_bit: cover property (@(posedge sys_clk) disable iff (!rst_b)
		extDirect && bitTick);
	c_odd_sck: cover property (@(posedge sys_clk) disable iff (!rst_b)
		sckOe && oddMck_r && $rose(sckOut));

endmodule
`default_nettype wire

// [src/sbrg_pkg.sv]
// Constants, field layout and carrier types of the baud rate generator
package sbrg_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MODE_OFS = 8'h04;
	localparam logic [7:0] BAUD_OFS = 8'h20;
	localparam logic [7:0] STAT_OFS = 8'h28;

	// ==========================================================
	// Field positions
	localparam int CTRL_RUN_BIT    = 0;
	localparam int MODE_SPEC_LSB   = 0;
	localparam int MODE_SEL_LSB    = 4;
	localparam int MODE_SYNC_BIT   = 8;
	localparam int MODE_OVER_BIT   = 19;
	localparam int BAUD_FRAC_LSB   = 16;
	localparam int STAT_SCK_BIT    = 16;
	localparam int STAT_STRETCH_BIT = 17;

	// ==========================================================
	// Encodings and reset values
	localparam logic [1:0]  SRC_MCK     = 2'h0;
	localparam logic [1:0]  SRC_MCKDIV  = 2'h1;
	localparam logic [1:0]  SRC_EXT     = 2'h3;
	localparam logic [3:0]  MODE_NORMAL = 4'h0;
	localparam logic [3:0]  OVS_TOP8    = 4'h7;
	localparam logic [3:0]  OVS_TOP16   = 4'hf;
	localparam int          PRE_DIV     = 8;
	localparam logic [31:0] REG_RESET   = 32'h0;

	typedef struct packed {
		logic        unitOn;
		logic [3:0]  special;
		logic [1:0]  clkSel;
		logic        syncMode;
		logic        over;
		logic [15:0] divisor;
		logic [2:0]  frac;
	} sbrg_cfg_t;

	localparam sbrg_cfg_t CFG_RESET = '0;

endpackage

// [tb/sbrg_far_model.sv]
// Far side model: external serial clock source feeding the pin input
`timescale 1ns/100ps
`default_nettype none
module sbrg_far_model #(
	parameter int HALF = 4
) (
	input  wire logic sys_clk,
	input  wire logic run,
	output var  logic sckIn
);
	int cnt = 0;

	// Stands low between bursts; each level spans HALF master cycles
	always @(posedge sys_clk) begin
		cnt <= (cnt + 1) % HALF;
		if (!run)
			sckIn <= 1'b0;
		else if (cnt == HALF - 1)
			sckIn <= ~sckIn;
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench of the baud rate generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        sys_clk, rst_b, psel, penable, pwrite, sckIn, extRun;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, sckOut, sckOe, sampleTick, bitTick;
	int          n_fail, comparisons;
	logic [32:0] expQ[$];

	sbrg_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sckIn(sckIn), .sckOut(sckOut),
		.sckOe(sckOe), .sampleTick(sampleTick), .bitTick(bitTick));
	sbrg_far_model far (.sys_clk(sys_clk), .run(extRun), .sckIn(sckIn));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Checking and reporting
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Read results are matched to the oldest pending expectation
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, expQ.pop_front());
	end

	// ==========================================================
	// Bus and measurement tasks
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_fail++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] md(input logic [3:0] sp,
		input logic [1:0] sel, input logic sy, input logic ov);
		return 32'(sp) | (32'(sel) << sbrg_pkg::MODE_SEL_LSB)
			| (32'(sy) << sbrg_pkg::MODE_SYNC_BIT)
			| (32'(ov) << sbrg_pkg::MODE_OVER_BIT);
	endfunction

	task automatic setup(input logic [31:0] b, input logic [31:0] m);
		apb(1'b1, sbrg_pkg::BAUD_OFS, b);
		apb(1'b1, sbrg_pkg::MODE_OFS, m);
		apb(1'b1, sbrg_pkg::CTRL_OFS, 32'h1);
	endtask

	// First two ticks are skipped: a period may straddle the reconfig
	task automatic meas(input logic b, input int n, input int exp);
		int c, k;
		c = 0;
		k = -2;
		while (k < n && c < 3000) begin
			@(posedge sys_clk);
			c++;
			if ((b ? bitTick : sampleTick) === 1'b1) begin
				k++;
				if (k == 0)
					c = 0;
			end
		end
		chk(33'(c), 33'(exp));
		if (c >= 3000)
			close_out();
	endtask

	task automatic quiet(input int n);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge sys_clk);
			if (sampleTick !== 1'b0 || bitTick !== 1'b0)
				k++;
		end
		chk(33'(k), 33'h0);
	endtask

	task automatic duty(input int exp);
		realtime t[4];
		int g;
		for (int i = 0; i < 4; i++) begin
			g = 0;
			while (sckOut !== i[0] && g < 500) begin
				#1;
				g++;
			end
			t[i] = $realtime;
		end
		chk(33'(int'(t[2] - t[1])), 33'(exp));
		chk(33'(int'(t[3] - t[2])), 33'(exp));
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		int cd, ov;
		{rst_b, psel, penable, pwrite, extRun} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		n_fail = 0;
		comparisons = 0;
		void'($urandom(32'hd11c14db));
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rd(sbrg_pkg::BAUD_OFS, 33'h0);
		rd(8'h10, {1'b1, 32'h0});
		apb(1'b1, sbrg_pkg::STAT_OFS, 32'hffff);
		rd(sbrg_pkg::STAT_OFS, 33'h0);
		apb(1'b1, sbrg_pkg::BAUD_OFS, 32'h0003_0005);
		rd(sbrg_pkg::BAUD_OFS, 33'h0_0003_0005);
		quiet(100);
		setup(32'h0, md(4'h0, sbrg_pkg::SRC_MCK, 1'b0, 1'b0));
		quiet(100);
		setup(32'h1, md(4'h0, sbrg_pkg::SRC_MCK, 1'b0, 1'b0));
		meas(1'b0, 4, 4);
		setup(32'h3, md(4'h0, sbrg_pkg::SRC_MCK, 1'b0, 1'b0));
		meas(1'b0, 1, 3);
		meas(1'b1, 1, 48);
		setup(32'h2, md(4'h0, sbrg_pkg::SRC_MCKDIV, 1'b0, 1'b0));
		meas(1'b0, 1, 2 * sbrg_pkg::PRE_DIV);
		setup(32'h0004_0002, md(4'h0, sbrg_pkg::SRC_MCK, 1'b0, 1'b1));
		meas(1'b0, 8, 20);
		setup(32'h0004_0002, md(4'h1, sbrg_pkg::SRC_MCK, 1'b0, 1'b1));
		meas(1'b0, 8, 16);
		for (int i = 0; i < 3; i++) begin
			cd = 2 + $urandom % 5;
			ov = $urandom % 2;
			setup(32'(cd), md(4'h0, sbrg_pkg::SRC_MCK, 1'b0, 1'(ov)));
			meas(1'b1, 1, 8 * (2 - ov) * cd);
		end
		setup(32'h3, md(4'h0, sbrg_pkg::SRC_MCK, 1'b0, 1'b0));
		apb(1'b1, sbrg_pkg::CTRL_OFS, 32'h0);
		quiet(60);
		apb(1'b1, sbrg_pkg::CTRL_OFS, 32'h1);
		meas(1'b0, 1, 3);
		setup(32'h5, md(4'h0, sbrg_pkg::SRC_MCK, 1'b1, 1'b0));
		meas(1'b1, 1, 5);
		chk({32'h0, sckOe}, 33'h1);
		setup(32'h3, md(4'h0, sbrg_pkg::SRC_MCK, 1'b1, 1'b0));
		duty(15);
		extRun <= 1'b1;
		setup(32'h7, md(4'h0, sbrg_pkg::SRC_EXT, 1'b1, 1'b0));
		meas(1'b1, 3, 24);
		close_out();
	end
endmodule
`default_nettype wire
